// ---- lcp_fabric_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcp_fabric_checker (
    input wire logic core_clk,
    input wire logic resetn,
    input wire lcp_pkg::lcp_cluster_ctl_t cluster_ctl,
    input wire lcp_pkg::lcp_cell_cfg_t [lcp_pkg::CELLS-1:0] cell_cfg,
    input wire logic [lcp_pkg::CELLS-1:0] operand_a_input,
    input wire logic [lcp_pkg::CELLS-1:0] operand_b_input,
    input wire logic [lcp_pkg::CELLS-1:0] load_data,
    input wire logic carry_in,
    input wire lcp_pkg::lcp_mc_cfg_t [lcp_pkg::MACROS-1:0] mc_cfg,
    input wire logic [1:0] global_clr,
    input wire logic [1:0] local_clr,
    input wire logic [1:0] clr_invert,
    input wire logic [lcp_pkg::CELLS-1:0] cell_comb_out,
    input wire logic [lcp_pkg::CELLS-1:0] cell_reg_out,
    input wire logic carry_out,
    input wire logic [lcp_pkg::MACROS-1:0] mc_out
);
    // ==========================================
    // helpers: adder check only holds when every cell is a plain adder
    logic adder_cfg;
    logic src0;
    logic en;
    logic cnt;
    assign src0 = (global_clr[0] | local_clr[0]) ^ clr_invert[0];
    assign en = cluster_ctl.clk_ena && !cluster_ctl.sync_clear && !cluster_ctl.sync_load;
    assign cnt = en && cluster_ctl.counter_mode && (&operand_a_input);
    always_comb begin
        adder_cfg = 1'b1;
        for (int i = 0; i < lcp_pkg::CELLS; i++)
            if (cell_cfg[i] != {lcp_pkg::SUM_TT_ADD, lcp_pkg::CARRY_TT_ADD, 2'b00}) adder_cfg = 1'b0;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ==========================================
    // properties
    property p_freeze; !cluster_ctl.clk_ena |=> $stable(cell_reg_out); endproperty
    property p_clear; cluster_ctl.clk_ena && cluster_ctl.sync_clear |=> cell_reg_out == '0; endproperty
    property p_load;
        cluster_ctl.clk_ena && !cluster_ctl.sync_clear && cluster_ctl.sync_load |=> cell_reg_out == $past(load_data);
    endproperty
    property p_up; cnt && (&operand_b_input) |=> cell_reg_out == $past(cell_reg_out) + 10'h001; endproperty
    property p_down; cnt && !(|operand_b_input) |=> cell_reg_out == $past(cell_reg_out) - 10'h001; endproperty
    property p_arith; en && !cluster_ctl.counter_mode |=> cell_reg_out == $past(cell_comb_out); endproperty
    property p_adder;
        adder_cfg |-> {carry_out, cell_comb_out} == 11'(operand_a_input) + 11'(operand_b_input) + 11'(carry_in);
    endproperty
    property p_mc_clr;
        mc_cfg[0].registered && mc_cfg[0].clr_sel == lcp_pkg::CLR_SRC0 && src0 |-> !mc_out[0];
    endproperty
    a_freeze: assert property (p_freeze) else $error("register moved while disabled");
    a_clear: assert property (p_clear) else $error("clear missed");
    a_load: assert property (p_load) else $error("load missed");
    a_up: assert property (p_up) else $error("up count wrong");
    a_down: assert property (p_down) else $error("down count wrong");
    a_arith: assert property (p_arith) else $error("result not registered");
    a_adder: assert property (p_adder) else $error("adder chain wrong");
    a_mc_clr: assert property (p_mc_clr) else $error("macrocell not cleared");
    c_clear: cover property (cluster_ctl.clk_ena && cluster_ctl.sync_clear);
    c_up: cover property (cnt && (&operand_b_input));
    c_mc_clr: cover property (mc_cfg[0].registered && src0);
endmodule // lcp_fabric_checker
bind lcp_logic_fabric lcp_fabric_checker i_chk (.core_clk, .resetn, .cluster_ctl, .cell_cfg, .operand_a_input,
    .operand_b_input, .load_data, .carry_in, .mc_cfg, .global_clr, .local_clr, .clr_invert, .cell_comb_out,
    .cell_reg_out, .carry_out, .mc_out);
`default_nettype wire

// ---- lcp_logic_cell.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcp_logic_cell (
    input wire lcp_pkg::lcp_cell_cfg_t cfg,
    input wire logic carry_in,
    input wire logic operand_a_input,
    input wire logic operand_b_input,
    input wire logic cascade_in,
    output logic result,
    output logic carry_out,
    output logic cascade_out
);
    // ==========================================
    // two three-input lookups
    logic lut_out;
    always_comb begin
        lut_out = lcp_pkg::lcp_lookup(cfg.sum_tt, carry_in, operand_a_input, operand_b_input);
        carry_out = lcp_pkg::lcp_lookup(cfg.carry_tt, carry_in, operand_a_input, operand_b_input);
        // cascade merge runs beside the carry chain, not instead of it
        if (!cfg.cascade_en) begin
            result = lut_out;
        end else if (cfg.cascade_or) begin
            result = lut_out | cascade_in;
        end else begin
            result = lut_out & cascade_in;
        end
        cascade_out = result;
    end
endmodule // lcp_logic_cell
`default_nettype wire

// ---- lcp_logic_fabric.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcp_logic_fabric (
    input wire logic core_clk,
    input wire logic resetn,
    input wire lcp_pkg::lcp_cluster_ctl_t cluster_ctl,
    input wire lcp_pkg::lcp_cell_cfg_t [lcp_pkg::CELLS-1:0] cell_cfg,
    input wire logic [lcp_pkg::CELLS-1:0] operand_a_input,
    input wire logic [lcp_pkg::CELLS-1:0] operand_b_input,
    input wire logic [lcp_pkg::CELLS-1:0] load_data,
    input wire logic carry_in,
    input wire logic cascade_in,
    input wire logic [lcp_pkg::PT_INPUTS-1:0] pt_inputs,
    input wire lcp_pkg::lcp_pt_cfg_t [lcp_pkg::MAX_TERMS-1:0] pt_cfg,
    input wire lcp_pkg::lcp_mc_cfg_t [lcp_pkg::MACROS-1:0] mc_cfg,
    input wire logic [1:0] global_clr,
    input wire logic [1:0] local_clr,
    input wire logic [1:0] clr_invert,
    output logic [lcp_pkg::CELLS-1:0] cell_comb_out,
    output logic [lcp_pkg::CELLS-1:0] cell_reg_out,
    output logic carry_out,
    output logic cascade_out,
    output logic [lcp_pkg::MACROS-1:0] mc_out
);

    // ==========================================
    // state
    typedef struct packed {
        logic [lcp_pkg::CELLS-1:0] cell_q;
    } lcp_fabric_state_t;

    lcp_fabric_state_t st_reg;
    lcp_fabric_state_t st_next;

    // ==========================================
    // cell cluster chains
    logic [lcp_pkg::CELLS:0] carry_chain;
    logic [lcp_pkg::CELLS:0] cascade_chain;
    logic [lcp_pkg::CELLS:0] count_chain;
    logic [lcp_pkg::CELLS-1:0] cell_result;
    logic [lcp_pkg::CELLS-1:0] cell_carry;
    logic [lcp_pkg::CELLS-1:0] count_toggle;

    assign carry_chain[0] = carry_in;
    assign cascade_chain[0] = cascade_in;
    // the lowest counter bit always sees a ripple input of one
    assign count_chain[0] = 1'b1;

    genvar gi;
    generate
        for (gi = 0; gi < lcp_pkg::CELLS; gi++) begin : g_cell
            lcp_logic_cell u_cell (
                .cfg(cell_cfg[gi]),
                .carry_in(carry_chain[gi]),
                .operand_a_input(operand_a_input[gi]),
                .operand_b_input(operand_b_input[gi]),
                .cascade_in(cascade_chain[gi]),
                .result(cell_result[gi]),
                .carry_out(cell_carry[gi]),
                .cascade_out(cascade_chain[gi+1])
            );

            assign carry_chain[gi+1] = cell_carry[gi];

            // counter bit: operand a enables, operand b picks up when high
            assign count_toggle[gi] = operand_a_input[gi] & count_chain[gi];
            assign count_chain[gi+1] = count_chain[gi] &
                (operand_b_input[gi] ? st_reg.cell_q[gi] : ~st_reg.cell_q[gi]);
        end
    endgenerate

    assign carry_out = carry_chain[lcp_pkg::CELLS];
    assign cascade_out = cascade_chain[lcp_pkg::CELLS];

    // ==========================================
    // cluster register next state
    // one set of clear and load lines serves the whole cluster, so in
    // counter mode every register follows the counter; cells that are not
    // part of it are to be used through their combinational output only
    always_comb begin
        st_next = st_reg;
        if (cluster_ctl.clk_ena) begin
            if (cluster_ctl.sync_clear) begin
                st_next.cell_q = '0;
            end else if (cluster_ctl.sync_load) begin
                st_next.cell_q = load_data;
            end else if (cluster_ctl.counter_mode) begin
                st_next.cell_q = st_reg.cell_q ^ count_toggle;
            end else begin
                st_next.cell_q = cell_result;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg.cell_q <= {lcp_pkg::CELLS{lcp_pkg::CELL_Q_RESET}};
        end else begin
            st_reg <= st_next;
        end
    end

    // both copies stay usable together in arithmetic mode
    assign cell_comb_out = cell_result;
    assign cell_reg_out = st_reg.cell_q;

    // ==========================================
    // product term array
    function automatic logic lcp_product_term(input lcp_pkg::lcp_pt_cfg_t cfg,
                                              input logic [lcp_pkg::PT_INPUTS-1:0] in);
        logic [lcp_pkg::PT_INPUTS-1:0] lit;
        lit = (in ^ cfg.polarity) | ~cfg.use_mask;
        return &lit;
    endfunction

    logic [lcp_pkg::MAX_TERMS-1:0] pterm;

    generate
        for (gi = 0; gi < lcp_pkg::MAX_TERMS; gi++) begin : g_pterm
            assign pterm[gi] = lcp_product_term(pt_cfg[gi], pt_inputs);
        end
    endgenerate

    // ==========================================
    // block level clear sources
    // a global or a local request asserts a source before its inversion
    logic [1:0] clear_src;

    generate
        for (gi = 0; gi < 2; gi++) begin : g_clr
            assign clear_src[gi] = (global_clr[gi] | local_clr[gi]) ^ clr_invert[gi];
        end
    endgenerate

    // ==========================================
    // macrocells and the parallel expander chain
    // sixteen macrocells leave at most fifteen neighbours of two terms each
    logic [lcp_pkg::MACROS:0] exp_chain;

    assign exp_chain[0] = 1'b0;

    generate
        for (gi = 0; gi < lcp_pkg::MACROS; gi++) begin : g_mc
            lcp_macrocell u_mc (
                .core_clk(core_clk),
                .resetn(resetn),
                .cfg(mc_cfg[gi]),
                .terms(pterm[gi*lcp_pkg::PT_PER_MC +: lcp_pkg::PT_PER_MC]),
                .expander_in(exp_chain[gi]),
                .clear_src(clear_src),
                .expander_out(exp_chain[gi+1]),
                .mc_out(mc_out[gi])
            );
        end
    endgenerate

endmodule // lcp_logic_fabric
`default_nettype wire

// ---- lcp_logic_fabric_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcp_logic_fabric_tb;
    // ==========================================
    // signals, instance, clock
    logic core_clk, resetn, carry_in, cascade_in, carry_out, cascade_out;
    lcp_pkg::lcp_cluster_ctl_t cluster_ctl;
    lcp_pkg::lcp_cell_cfg_t [lcp_pkg::CELLS-1:0] cell_cfg;
    logic [9:0] operand_a_input, operand_b_input, load_data, cell_comb_out, cell_reg_out;
    logic [15:0] pt_inputs, mc_out;
    lcp_pkg::lcp_pt_cfg_t [lcp_pkg::MAX_TERMS-1:0] pt_cfg;
    lcp_pkg::lcp_mc_cfg_t [lcp_pkg::MACROS-1:0] mc_cfg;
    logic [1:0] global_clr, local_clr, clr_invert;
    int n_fail = 0;
    int n_tests = 0;
    lcp_logic_fabric i_dut (.core_clk, .resetn, .cluster_ctl, .cell_cfg, .operand_a_input, .operand_b_input,
        .load_data, .carry_in, .cascade_in, .pt_inputs, .pt_cfg, .mc_cfg, .global_clr, .local_clr, .clr_invert,
        .cell_comb_out, .cell_reg_out, .carry_out, .cascade_out, .mc_out);
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // ==========================================
    // shared tasks
    // wide enough for the joined register and result words, nothing is cut
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("counts: tests=%0d errors=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic step(input logic [9:0] x, input logic [9:0] y, input logic c);
        @(negedge core_clk);
        operand_a_input = x;
        operand_b_input = y;
        carry_in = c;
        #1;
    endtask
    // ==========================================
    // scenarios
    task automatic t_add(input logic [9:0] x, input logic [9:0] y, input logic c);
        logic [10:0] e;
        e = 11'(x) + 11'(y) + 11'(c);
        step(x, y, c);
        chk(cell_comb_out, e[9:0]);
        chk(carry_out, e[10]);
    endtask
    task automatic t_cascade;
        cell_cfg[0].cascade_en = 1'b1;
        cascade_in = 1'b0;
        step(10'h3ff, 10'h001, 1'b1);
        chk({carry_out, cell_comb_out}, 11'h400);
        cascade_in = 1'b1;
        #1;
        chk({carry_out, cell_comb_out}, 11'h401);
        cell_cfg[0].cascade_or = 1'b1;
        step(10'h200, 10'h000, 1'b0);
        chk({cascade_out, carry_out, cell_comb_out}, 12'ha01);
        cell_cfg[0] = {lcp_pkg::SUM_TT_ADD, lcp_pkg::CARRY_TT_ADD, 2'b00};
    endtask
    task automatic t_arith_reg;
        step(10'h0f0, 10'h00f, 1'b0);
        cluster_ctl.clk_ena = 1'b1;
        @(negedge core_clk);
        chk({cell_reg_out, cell_comb_out}, 20'h3_fcff);
    endtask
    task automatic t_counter;
        cluster_ctl = '{counter_mode: 1'b1, clk_ena: 1'b1, sync_clear: 1'b0, sync_load: 1'b1};
        load_data = 10'h3fe;
        step(10'h3ff, 10'h3ff, 1'b0);
        @(negedge core_clk);
        chk(cell_reg_out, 10'h3fe);
        cluster_ctl.sync_load = 1'b0;
        @(negedge core_clk);
        chk(cell_reg_out, 10'h3ff);
        step(10'h3ff, 10'h000, 1'b0);
        chk(cell_reg_out, 10'h000);
        step(10'h000, 10'h000, 1'b0);
        chk(cell_reg_out, 10'h3ff);
        cluster_ctl.sync_load = 1'b1;
        @(negedge core_clk);
        chk(cell_reg_out, 10'h3fe);
        cluster_ctl.clk_ena = 1'b0;
        @(negedge core_clk);
        chk(cell_reg_out, 10'h3fe);
        cluster_ctl.clk_ena = 1'b1;
        cluster_ctl.sync_clear = 1'b1;
        @(negedge core_clk);
        chk(cell_reg_out, 10'h000);
        // cell 4 sees a full ripple but its own enable is low, so it must hold
        cluster_ctl.sync_clear = 1'b0;
        load_data = 10'h00f;
        @(negedge core_clk);
        cluster_ctl.sync_load = 1'b0;
        step(10'h00f, 10'h3ff, 1'b0);
        @(negedge core_clk);
        chk(cell_reg_out, 10'h000);
        cluster_ctl = '0;
    endtask
    task automatic t_macro;
        pt_cfg[0].use_mask = 16'h0001;
        pt_cfg[1].use_mask = 16'h0002;
        pt_inputs = 16'h0001;
        #1;
        chk(mc_out[0], 1'b1);
        mc_cfg[0].invert_term0 = 1'b1;
        #1;
        chk(mc_out[0], 1'b0);
        mc_cfg[0] = '0;
        mc_cfg[0].export_term = 2'b01;
        mc_cfg[1].borrow_en = 1'b1;
        #1;
        chk(mc_out[1:0], 2'b10);
        mc_cfg[0].export_term = 2'b10;
        mc_cfg[1] = '0;
        mc_cfg[1].xor_polarity = 1'b1;
        mc_cfg[2].borrow_en = 1'b1;
        pt_cfg[1].polarity = 16'h0002;
        #1;
        chk(mc_out[2:0], 3'b111);
        pt_cfg[1].polarity = 16'h0000;
        mc_cfg = '0;
        mc_cfg[0].registered = 1'b1;
        pt_inputs = 16'h0000;
        @(negedge core_clk);
        pt_inputs = 16'h0001;
        #1;
        chk(mc_out[0], 1'b0);
        @(negedge core_clk);
        chk(mc_out[0], 1'b1);
        mc_cfg[0].clr_sel = lcp_pkg::CLR_SRC0;
        clr_invert = 2'b01;
        #1;
        chk(mc_out[0], 1'b0);
        @(negedge core_clk);
        chk(mc_out[0], 1'b0);
        clr_invert = 2'b00;
        @(negedge core_clk);
        chk(mc_out[0], 1'b1);
        mc_cfg[0].clr_sel = lcp_pkg::CLR_SRC1;
        local_clr = 2'b10;
        #1;
        chk(mc_out[0], 1'b0);
        local_clr = 2'b00;
        @(negedge core_clk);
        chk(mc_out[0], 1'b1);
        global_clr = 2'b10;
        #1;
        chk(mc_out[0], 1'b0);
        mc_cfg[0].clr_sel = lcp_pkg::CLR_NONE;
        @(negedge core_clk);
        chk(mc_out[0], 1'b1);
        global_clr = 2'b00;
    endtask
    // ==========================================
    // main sequence; the watchdog is far beyond the expected run time
    initial begin
        resetn = 1'b0;
        {cluster_ctl, operand_a_input, operand_b_input, load_data, carry_in, cascade_in} = '0;
        {pt_inputs, mc_cfg, global_clr, local_clr, clr_invert} = '0;
        for (int i = 0; i < lcp_pkg::CELLS; i++) cell_cfg[i] = {lcp_pkg::SUM_TT_ADD, lcp_pkg::CARRY_TT_ADD, 2'b00};
        for (int i = 0; i < lcp_pkg::MAX_TERMS; i++) pt_cfg[i] = {16'h0004, 16'h0000};
        repeat (2) @(negedge core_clk);
        resetn = 1'b1;
        chk(cell_reg_out, 10'h000);
        t_add(10'h3ff, 10'h001, 1'b0);
        t_add(10'h2aa, 10'h155, 1'b1);
        t_add(10'h123, 10'h2dd, 1'b1);
        t_cascade;
        t_arith_reg;
        t_counter;
        t_macro;
        complete_run;
    end
    initial begin
        #50000;
        n_fail++;
        complete_run;
    end
endmodule // lcp_logic_fabric_tb
`default_nettype wire

// ---- lcp_macrocell.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcp_macrocell (
    input wire logic core_clk,
    input wire logic resetn,
    input wire lcp_pkg::lcp_mc_cfg_t cfg,
    input wire logic [lcp_pkg::PT_PER_MC-1:0] terms,
    input wire logic expander_in,
    input wire logic [1:0] clear_src,
    output logic expander_out,
    output logic mc_out
);
    typedef struct packed {
        logic q;
    } lcp_mc_state_t;
    lcp_mc_state_t st_reg;
    lcp_mc_state_t st_next;
    logic term0;
    logic own_sum;
    logic exported;
    logic or_sum;
    logic d;
    logic clr_hit;
    logic clr_n;
    // ==========================================
    // select matrix and or/xor
    always_comb begin
        term0 = terms[0] ^ cfg.invert_term0;
        own_sum = (term0 & ~cfg.export_term[0]) | (terms[1] & ~cfg.export_term[1]);
        exported = (term0 & cfg.export_term[0]) | (terms[1] & cfg.export_term[1]);
        // each borrowed set adds one gate level of delay along the chain
        or_sum = own_sum | (cfg.borrow_en & expander_in);
        expander_out = exported | (~cfg.borrow_en & expander_in);
        d = or_sum ^ cfg.xor_polarity;
        st_next = st_reg;
        st_next.q = d;
        mc_out = cfg.registered ? st_reg.q : d;
        case (cfg.clr_sel)
            lcp_pkg::CLR_SRC0: clr_hit = clear_src[0];
            lcp_pkg::CLR_SRC1: clr_hit = clear_src[1];
            default: clr_hit = 1'b0;
        endcase
    end
    // clear sources must be glitch free, any pulse clears the register
    assign clr_n = resetn & ~clr_hit;
    // ==========================================
    // programmable register
    always_ff @(posedge core_clk or negedge clr_n) begin
        if (!clr_n) begin
            st_reg.q <= lcp_pkg::MC_Q_RESET;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule // lcp_macrocell
`default_nettype wire

// ---- lcp_pkg.sv ----
`default_nettype none
package lcp_pkg;
    // ==========================================
    // sizes of one cluster and one array block
    localparam int CELLS = 10;
    localparam int MACROS = 16;
    localparam int PT_PER_MC = 2;
    localparam int PT_INPUTS = 16;
    localparam int MAX_TERMS = 32;
    localparam int EXP_SETS = 15;
    localparam int EXP_PER_SET = 2;
    localparam int LUT_WIDTH = 8;
    // ==========================================
    // lookup index positions and adder defaults
    localparam int IDX_CIN = 2;
    localparam int IDX_A = 1;
    localparam int IDX_B = 0;
    localparam logic [7:0] SUM_TT_ADD = 8'h96;
    localparam logic [7:0] CARRY_TT_ADD = 8'he8;
    localparam logic CELL_Q_RESET = 1'h0;
    localparam logic MC_Q_RESET = 1'h0;
    // ==========================================
    // types
    typedef enum logic [1:0] {CLR_NONE, CLR_SRC0, CLR_SRC1} lcp_clr_sel_t;
    typedef struct packed {
        logic [LUT_WIDTH-1:0] sum_tt;
        logic [LUT_WIDTH-1:0] carry_tt;
        logic cascade_en;
        logic cascade_or;
    } lcp_cell_cfg_t;
    typedef struct packed {
        logic counter_mode;
        logic clk_ena;
        logic sync_clear;
        logic sync_load;
    } lcp_cluster_ctl_t;
    typedef struct packed {
        logic [PT_INPUTS-1:0] use_mask;
        logic [PT_INPUTS-1:0] polarity;
    } lcp_pt_cfg_t;
    typedef struct packed {
        logic [PT_PER_MC-1:0] export_term;
        logic invert_term0;
        logic borrow_en;
        logic xor_polarity;
        logic registered;
        lcp_clr_sel_t clr_sel;
    } lcp_mc_cfg_t;
    // ==========================================
    // three-input lookup
    function automatic logic lcp_lookup(input logic [LUT_WIDTH-1:0] tt, input logic cin,
                                        input logic a, input logic b);
        logic [2:0] idx;
        idx = {cin, a, b};
        return tt[idx];
    endfunction
endpackage
`default_nettype wire
